// *** design/fwd_watchdog.sv ***
/*
  Free-running watchdog with two-key clear, selectable overflow period,
  non-maskable interrupt on first overflow and reset request on second.
  Assumes an APB master on pclk, a low-speed oscillator status pin and
  low-power mode levels from the clock controller on pclk.
*/
// Local design decision: register access over APB.
`timescale 1ns/1ps
module fwd_watchdog #(
  parameter int LS_HZ      = fwd_pkg::LS_HZ,
  parameter int PER0_TICKS = fwd_pkg::PER0_TICKS,
  parameter int PER1_TICKS = fwd_pkg::PER1_TICKS,
  parameter int PER2_TICKS = fwd_pkg::PER2_TICKS,
  parameter int PER3_TICKS = fwd_pkg::PER3_TICKS
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [fwd_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // System side
  input  wire logic                        ls_osc_running,
  input  wire logic                        stop_mode,
  input  wire logic                        halt_mode,
  output logic                             watchdog_irq,
  output logic                             halt_release,
  output logic                             wdt_reset_req,
  output logic                             irq
);

  localparam int HOLD_LEN = fwd_pkg::HOLD_CYC;       // Hold length, cycles
  localparam logic [9:0] HOLD_LAST = 10'(HOLD_LEN - 1);

  logic                      osc_meta_reg;    // Sync stage 1
  logic                      osc_run_reg;     // Sync stage 2
  fwd_pkg::fwd_state_t       state_reg;       // Watchdog stage
  logic [fwd_pkg::CNT_W-1:0] cnt_reg;         // Low-speed tick counter
  logic [9:0]                hold_reg;        // Hold cycle counter
  logic                      ptr_reg;         // Toggle pointer
  logic                      key1_ok_reg;     // First key accepted
  logic [1:0]                psel_reg;        // Period select field
  fwd_pkg::fwd_evt_t         stat_reg;        // Sticky events
  fwd_pkg::fwd_evt_t         mask_reg;        // Event mask
  logic                      tick;            // Low-speed tick enable
  logic                      run;             // Counter may advance
  logic                      wr_acc;          // APB write access
  logic [15:0]               idx;             // Register index
  logic                      key_wr;          // Write to clear-key
  logic                      do_clear;        // Valid second key
  logic                      ovf;             // Counter overflow
  logic [fwd_pkg::CNT_W-1:0] per_last;        // Last count of period
  fwd_pkg::fwd_evt_t         evt;             // Events this cycle

  // Oscillator status synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_meta_reg <= 1'b0;
      osc_run_reg  <= 1'b0;
    end else begin
      osc_meta_reg <= ls_osc_running;
      osc_run_reg  <= osc_meta_reg;
    end
  end

  // No software gate: only oscillator, stop mode and the hold stage stall the count
  assign run = osc_run_reg && !stop_mode && (state_reg != fwd_pkg::FWD_HOLD);

  // Low-speed time base
  fwd_tick_gen #(
    .CLK_HZ (fwd_pkg::CLK_HZ),
    .LS_HZ  (LS_HZ)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .tick    (tick)
  );

  // Bus decode; zero wait states
  assign idx     = paddr[17:2];
  assign wr_acc  = psel && penable && pwrite;
  assign key_wr  = wr_acc && (idx == fwd_pkg::KEY_IDX) && (state_reg != fwd_pkg::FWD_HOLD);
  assign do_clear = key_wr && ptr_reg && key1_ok_reg && (pwdata[7:0] == fwd_pkg::KEY_SECOND);
  assign pready  = 1'b1;
  // Error on an unmapped index or on a byte address off the word grid
  assign pslverr = psel && penable && (!(idx == fwd_pkg::KEY_IDX || idx == fwd_pkg::PSEL_IDX
                   || idx == fwd_pkg::STAT_IDX || idx == fwd_pkg::MASK_IDX) || paddr[1:0] != 2'h0);

  // Period lookup
  always_comb begin
    unique case (psel_reg)
      2'h0: per_last = fwd_pkg::CNT_W'(PER0_TICKS - 1);
      2'h1: per_last = fwd_pkg::CNT_W'(PER1_TICKS - 1);
      2'h2: per_last = fwd_pkg::CNT_W'(PER2_TICKS - 1);
      2'h3: per_last = fwd_pkg::CNT_W'(PER3_TICKS - 1);
    endcase
  end

  assign ovf = run && tick && (cnt_reg >= per_last) && (state_reg != fwd_pkg::FWD_FIRED);
  // Both event bits from one driver; the stage picks which one fires
  assign evt = '{reset_ev: ovf && (state_reg == fwd_pkg::FWD_ARMED),
                 nmi_ev:   ovf && (state_reg == fwd_pkg::FWD_RUN)};

  // Tick counter, restarts on clear and overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (do_clear || ovf || state_reg == fwd_pkg::FWD_HOLD) begin
      cnt_reg <= '0;
    end else if (run && tick) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Stage machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= fwd_pkg::FWD_RUN;
      hold_reg  <= '0;
    end else begin
      unique case (state_reg)
        // Normal count
        fwd_pkg::FWD_RUN: begin
          if (evt.nmi_ev) begin
            state_reg <= fwd_pkg::FWD_HOLD;
            hold_reg  <= '0;
          end
        end
        // Counter and pointer held in reset state
        fwd_pkg::FWD_HOLD: begin
          if (hold_reg == HOLD_LAST) begin
            state_reg <= fwd_pkg::FWD_ARMED;
          end else begin
            hold_reg <= hold_reg + 1'b1;
          end
        end
        // Counting toward the second overflow
        fwd_pkg::FWD_ARMED: begin
          if (do_clear) begin
            state_reg <= fwd_pkg::FWD_RUN;
          end else if (evt.reset_ev) begin
            state_reg <= fwd_pkg::FWD_FIRED;
          end
        end
        // Reset requested; waits for system reset
        fwd_pkg::FWD_FIRED: begin
          state_reg <= fwd_pkg::FWD_FIRED;
        end
      endcase
    end
  end

  // Toggle pointer and first-key latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg     <= 1'b0;
      key1_ok_reg <= 1'b0;
    end else if (ovf) begin
      ptr_reg     <= 1'b0;
      key1_ok_reg <= 1'b0;
    end else if (key_wr) begin
      ptr_reg     <= !ptr_reg;
      key1_ok_reg <= !ptr_reg && (pwdata[7:0] == fwd_pkg::KEY_FIRST);
    end
  end

  // Period select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel_reg <= fwd_pkg::PSEL_RST;
    end else if (wr_acc && idx == fwd_pkg::PSEL_IDX) begin
      psel_reg <= pwdata[1:0];
    end
  end

  // Sticky status and mask; set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else begin
      if (wr_acc && idx == fwd_pkg::STAT_IDX) begin
        stat_reg <= (stat_reg & ~pwdata[1:0]) | evt;
      end else begin
        stat_reg <= stat_reg | evt;
      end
      if (wr_acc && idx == fwd_pkg::MASK_IDX) begin
        mask_reg <= pwdata[1:0];
      end
    end
  end

  // System outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_irq  <= 1'b0;
      halt_release  <= 1'b0;
      wdt_reset_req <= 1'b0;
      irq           <= 1'b0;
    end else begin
      watchdog_irq  <= evt.nmi_ev;
      halt_release  <= evt.nmi_ev && halt_mode;
      wdt_reset_req <= wdt_reset_req || evt.reset_ev;
      irq           <= |((stat_reg | evt) & mask_reg);
    end
  end

  // Read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr[17:2])
        fwd_pkg::KEY_IDX:  prdata <= {31'h0, ptr_reg};
        fwd_pkg::PSEL_IDX: prdata <= {30'h0, psel_reg};
        fwd_pkg::STAT_IDX: prdata <= {30'h0, stat_reg};
        fwd_pkg::MASK_IDX: prdata <= {30'h0, mask_reg};
        default:           prdata <= '0;
      endcase
    end
  end

  // Checks
  localparam int HOLD_MAX = HOLD_LEN;  // Hold must end within its own length after the first eight held cycles

  sequence s_key1;
    key_wr && !ptr_reg && pwdata[7:0] == fwd_pkg::KEY_FIRST && !ovf;
  endsequence

  sequence s_key2;
    key_wr && ptr_reg && pwdata[7:0] == fwd_pkg::KEY_SECOND && !ovf;
  endsequence

  property p_clear_seq;
    @(posedge pclk) disable iff (!presetn)
    s_key1 ##1 (!key_wr && !ovf)[*2] ##1 s_key2 |=> cnt_reg == '0;
  endproperty
  a_clear_seq: assert property (p_clear_seq) else $error("two-key clear failed");

  property p_wrong_key;
    @(posedge pclk) disable iff (!presetn)
    key_wr && ptr_reg |=> !key1_ok_reg;
  endproperty
  a_wrong_key: assert property (p_wrong_key) else $error("first key taken at pointer one");

  property p_ptr_ovf;
    @(posedge pclk) disable iff (!presetn)
    ovf |=> !ptr_reg && !key1_ok_reg;
  endproperty
  a_ptr_ovf: assert property (p_ptr_ovf) else $error("pointer not zeroed on overflow");

  property p_ptr_toggle;
    @(posedge pclk) disable iff (!presetn)
    key_wr && !ovf |=> ptr_reg != $past(ptr_reg);
  endproperty
  a_ptr_toggle: assert property (p_ptr_toggle) else $error("pointer did not toggle");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    $rose(state_reg == fwd_pkg::FWD_HOLD) |->
      (!ptr_reg && cnt_reg == '0 && state_reg == fwd_pkg::FWD_HOLD)[*8]
      ##[1:HOLD_MAX] state_reg == fwd_pkg::FWD_ARMED;
  endproperty
  a_hold: assert property (p_hold) else $error("hold after first overflow wrong");

  property p_nmi;
    @(posedge pclk) disable iff (!presetn)
    ovf && state_reg == fwd_pkg::FWD_RUN |=> watchdog_irq ##1 !watchdog_irq;
  endproperty
  a_nmi: assert property (p_nmi) else $error("missing watchdog interrupt");

  property p_reset;
    @(posedge pclk) disable iff (!presetn)
    ovf && state_reg == fwd_pkg::FWD_ARMED |=> wdt_reset_req ##1 wdt_reset_req;
  endproperty
  a_reset: assert property (p_reset) else $error("missing reset request");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    stop_mode && !do_clear && state_reg != fwd_pkg::FWD_HOLD |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved in stop mode");

  property p_period;
    @(posedge pclk) disable iff (!presetn)
    run && tick && psel_reg == 2'h0 && cnt_reg == fwd_pkg::CNT_W'(PER0_TICKS - 1)
      && state_reg == fwd_pkg::FWD_RUN |=> cnt_reg == '0 && watchdog_irq;
  endproperty
  a_period: assert property (p_period) else $error("short period overflow wrong");

  property p_key_read;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr[17:2] == fwd_pkg::KEY_IDX |=> prdata == {31'h0, $past(ptr_reg)};
  endproperty
  a_key_read: assert property (p_key_read) else $error("pointer readback wrong");

endmodule

// *** design/fwd_pkg.sv ***
/*
  Shared constants and types of the free-running watchdog: register
  indices, field layout, reset values, keys, timing and state codes.
  Assumes a 40 MHz APB clock and a 32.768 kHz low-speed time base.
*/
package fwd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] KEY_IDX   = 16'hF00E;  // Clear-key register
  localparam logic [15:0] PSEL_IDX  = 16'hF00F;  // Period select register
  localparam logic [15:0] STAT_IDX  = 16'hF010;  // Sticky event status
  localparam logic [15:0] MASK_IDX  = 16'hF011;  // Event interrupt mask
  localparam int          ADDR_W    = 18;        // APB address width

  // Reset values and keys
  localparam logic [1:0]  PSEL_RST  = 2'h2;      // 2 s period
  localparam logic [7:0]  KEY_FIRST = 8'h5A;     // First clear key
  localparam logic [7:0]  KEY_SECOND = 8'hA5;    // Second clear key

  // Time base
  localparam int CLK_HZ     = 40000000;          // pclk rate
  localparam int CLK_NS     = 25;                // pclk period
  localparam int LS_HZ      = 32768;             // Low-speed clock rate
  localparam int HOLD_NS    = 15250;             // Half low-speed cycle
  localparam int HOLD_CYC   = HOLD_NS / CLK_NS;  // Rounded down
  localparam int ACC_W      = 26;                // Phase accumulator width

  // Overflow periods in ms and in low-speed ticks
  localparam int PER0_MS    = 125;
  localparam int PER1_MS    = 500;
  localparam int PER2_MS    = 2000;
  localparam int PER3_MS    = 8000;
  localparam int PER0_TICKS = PER0_MS * LS_HZ / 1000;
  localparam int PER1_TICKS = PER1_MS * LS_HZ / 1000;
  localparam int PER2_TICKS = PER2_MS * LS_HZ / 1000;
  localparam int PER3_TICKS = PER3_MS * LS_HZ / 1000;
  localparam int CNT_W      = 19;                // Holds 262144

  // Event bits, same layout in status and mask
  typedef struct packed {
    logic reset_ev;                              // Second overflow
    logic nmi_ev;                                // First overflow
  } fwd_evt_t;

  // Watchdog stage, Gray along run-hold-armed-fired
  typedef enum logic [1:0] {
    FWD_RUN   = 2'b00,
    FWD_HOLD  = 2'b01,
    FWD_ARMED = 2'b11,
    FWD_FIRED = 2'b10
  } fwd_state_t;

endpackage

// *** design/fwd_tick_gen.sv ***
/*
  Fractional divider producing a one-cycle low-speed tick enable
  from pclk. Assumes LS_HZ is below CLK_HZ.
*/
`timescale 1ns/1ps
module fwd_tick_gen #(
  parameter int CLK_HZ = 40000000,
  parameter int LS_HZ  = 32768
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic run,    // Advance the time base
  // Tick out
  output logic      tick    // One pulse per low-speed cycle
);

  localparam logic [fwd_pkg::ACC_W-1:0] STEP = fwd_pkg::ACC_W'(LS_HZ);
  localparam logic [fwd_pkg::ACC_W-1:0] WRAP = fwd_pkg::ACC_W'(CLK_HZ - LS_HZ);

  logic [fwd_pkg::ACC_W-1:0] acc_reg;  // Phase accumulator

  // Accumulate; wrap emits a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= '0;
      tick    <= 1'b0;
    end else if (run) begin
      if (acc_reg >= WRAP) begin
        acc_reg <= acc_reg - WRAP;
        tick    <= 1'b1;
      end else begin
        acc_reg <= acc_reg + STEP;
        tick    <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule

// *** tb/fwd_sys_model.sv ***
/* System-side model: oscillator, stop and halt control, interrupt and
   reset controllers. Assumes the watchdog and the bench on pclk. */
`timescale 1ns/1ps
module fwd_sys_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench controls
  input  wire logic osc_en,
  input  wire logic stop_req,
  input  wire logic halt_req,
  // From the watchdog
  input  wire logic watchdog_irq,
  input  wire logic halt_release,
  input  wire logic wdt_reset_req,
  // To the watchdog
  output logic      ls_osc_running,
  output logic      stop_mode,
  output logic      halt_mode,
  // Observations
  output int        nmi_count,
  output logic      sys_reset
);
  // Oscillator and stop level follow the bench directly
  assign ls_osc_running = osc_en;
  assign stop_mode      = stop_req;

  // Halt entered on request, left only on the release pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) halt_mode <= 1'b0;
    else if (halt_release) halt_mode <= 1'b0;
    else if (halt_req) halt_mode <= 1'b1;
  end

  // Interrupt controller counts requests; reset controller latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_count <= 0;
      sys_reset <= 1'b0;
    end else begin
      if (watchdog_irq) nmi_count <= nmi_count + 1;
      sys_reset <= sys_reset | wdt_reset_req;
    end
  end
endmodule

// *** tb/tb_top.sv ***
/* Self-checking bench of the watchdog with shortened periods.
   Assumes the system model and an APB master on pclk. */
`timescale 1ns/1ps
module tb_top;
  localparam logic [17:0] A_KEY = {fwd_pkg::KEY_IDX, 2'h0};   // Clear-key
  localparam logic [17:0] A_PER = {fwd_pkg::PSEL_IDX, 2'h0};  // Period select
  localparam logic [17:0] A_STA = {fwd_pkg::STAT_IDX, 2'h0};  // Status
  localparam logic [17:0] A_MSK = {fwd_pkg::MASK_IDX, 2'h0};  // Mask
  localparam logic [17:0] A_BAD = 18'h3C048;                  // Unmapped
  localparam logic [31:0] K1    = {24'h0, fwd_pkg::KEY_FIRST};  // First key
  localparam logic [31:0] K2    = {24'h0, fwd_pkg::KEY_SECOND}; // Second key
  localparam int          TK    = 10;                         // pclk per tick
  logic        pclk = 1'b0;        // Bus clock
  logic        presetn;            // Reset, active low
  logic        psel, penable, pwrite;
  logic [17:0] paddr;              // Byte address
  logic [31:0] pwdata, prdata, rd; // Bus data, last read
  logic        pready, pslverr, er;
  logic        ls_osc_running, stop_mode, halt_mode, sys_reset;
  logic        watchdog_irq, halt_release, wdt_reset_req, irq;
  logic        osc_en, stop_req, halt_req;
  int          nmi_count, fails, samples_checked, n, c;

  // Design with ten pclk per tick and short periods
  fwd_watchdog #(.LS_HZ(4000000), .PER0_TICKS(8), .PER1_TICKS(16),
    .PER2_TICKS(32), .PER3_TICKS(64)) u_fwd_watchdog (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ls_osc_running(ls_osc_running),
    .stop_mode(stop_mode), .halt_mode(halt_mode), .watchdog_irq(watchdog_irq),
    .halt_release(halt_release), .wdt_reset_req(wdt_reset_req), .irq(irq));

  // System side
  fwd_sys_model u_fwd_sys_model (
    .pclk(pclk), .presetn(presetn), .osc_en(osc_en), .stop_req(stop_req),
    .halt_req(halt_req), .watchdog_irq(watchdog_irq), .halt_release(halt_release),
    .wdt_reset_req(wdt_reset_req), .ls_osc_running(ls_osc_running),
    .stop_mode(stop_mode), .halt_mode(halt_mode), .nmi_count(nmi_count),
    .sys_reset(sys_reset));

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // Count a comparison, report a difference
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Proper two-key clear
  task automatic clr;
    apb(1'b1, A_KEY, K1);
    apb(1'b1, A_KEY, K2);
  endtask

  // Wait for the next interrupt, cycles counted in n
  task automatic wait_nmi(input int lim);
    int c0;
    c0 = nmi_count;
    n  = 0;
    while (nmi_count == c0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Reset values and an unmapped place
  task automatic t_regs;
    apb(1'b0, A_KEY, 32'h0);
    chk("key reset", 32'h0, rd & 32'h1);
    apb(1'b0, A_PER, 32'h0);
    chk("period reset", 32'h2, rd & 32'h3);
    apb(1'b0, A_MSK, 32'h0);
    chk("mask reset", 32'h0, rd & 32'h3);
    chk("mapped no error", 32'h0, {31'h0, er});
    chk("ready level", 32'h1, {31'h0, pready});
    apb(1'b0, A_BAD, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b0, A_KEY | 18'h1, 32'h0);
    chk("unaligned error", 32'h1, {31'h0, er});
    $display("test regs done");
  endtask

  // Start on oscillator, retry first key through the hold, interrupts
  task automatic t_start;
    int tries;
    repeat (400) @(posedge pclk);
    chk("nmi before osc", 32'h0, nmi_count);
    osc_en <= 1'b1;
    wait_nmi(400);
    chk("nmi after osc", 32'h1, nmi_count);
    tries = 0;
    do begin
      apb(1'b1, A_KEY, K1);
      apb(1'b0, A_KEY, 32'h0);
      if (tries == 0) chk("pointer in hold", 32'h0, rd & 32'h1);
      tries++;
    end while (rd[0] !== 1'b1 && tries < 200);
    chk("hold length", 32'h1, 32'(tries > 80 && tries < 200));
    apb(1'b1, A_KEY, K2);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, A_MSK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'b1, A_STA, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test start done");
  endtask

  // Pointer readback, repeated clears, a misordered sequence
  task automatic t_keys;
    apb(1'b1, A_PER, 32'h0);
    clr;
    c = nmi_count;
    repeat (6) begin
      repeat (40) @(posedge pclk);
      apb(1'b1, A_KEY, K1);
      apb(1'b0, A_KEY, 32'h0);
      chk("pointer after first", 32'h1, rd & 32'h1);
      apb(1'b1, A_KEY, K2);
      apb(1'b0, A_KEY, 32'h0);
      chk("pointer after second", 32'h0, rd & 32'h1);
    end
    chk("no nmi while cleared", c, nmi_count);
    repeat (30) @(posedge pclk);
    apb(1'b1, A_KEY, K1);
    apb(1'b1, A_KEY, K1);
    apb(1'b1, A_KEY, K2);
    wait_nmi(60);
    chk("nmi despite bad order", c + 1, nmi_count);
    apb(1'b0, A_KEY, 32'h0);
    chk("pointer after overflow", 32'h0, rd & 32'h1);
    repeat (620) @(posedge pclk);
    clr;
    $display("test keys done");
  endtask

  // Every period code and its length
  task automatic t_period;
    for (int s = 0; s < 4; s++) begin
      clr;
      apb(1'b1, A_PER, 32'(s));
      apb(1'b0, A_PER, 32'h0);
      chk("period field", 32'(s), rd & 32'h3);
      clr;
      wait_nmi(2000);
      chk("period length", 32'h1, 32'(n >= (8 << s) * TK - TK - 2 && n <= (8 << s) * TK + 15));
      repeat (620) @(posedge pclk);
      clr;
    end
    $display("test period done");
  endtask

  // Stop freezes; halt keeps counting, released, then second overflow
  task automatic t_modes;
    clr;
    apb(1'b1, A_PER, 32'h0);
    c = nmi_count;
    stop_req <= 1'b1;
    repeat (300) @(posedge pclk);
    chk("no nmi in stop", c, nmi_count);
    stop_req <= 1'b0;
    clr;
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    wait_nmi(200);
    chk("nmi in halt", c + 1, nmi_count);
    repeat (2) @(posedge pclk);
    chk("halt released", 32'h0, {31'h0, halt_mode});
    chk("no early reset", 32'h0, {31'h0, sys_reset});
    n = 0;
    while (sys_reset !== 1'b1 && n < 900) begin
      @(posedge pclk);
      n++;
    end
    chk("second overflow reset", 32'h1, {31'h0, sys_reset});
    repeat (100) @(posedge pclk);
    chk("reset request held", 32'h1, {31'h0, wdt_reset_req});
    apb(1'b0, A_STA, 32'h0);
    chk("status both events", 32'h3, rd & 32'h3);
    apb(1'b1, A_KEY, 32'h0);
    apb(1'b0, A_KEY, 32'h0);
    chk("pointer on any write", 32'h1, rd & 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset request cleared", 32'h0, {31'h0, wdt_reset_req});
    apb(1'b0, A_KEY, 32'h0);
    chk("pointer after reset", 32'h0, rd & 32'h1);
    apb(1'b0, A_STA, 32'h0);
    chk("status after reset", 32'h0, rd & 32'h3);
    $display("test modes done");
  endtask

  // Counts, verdict, end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    osc_en = 1'b0;
    stop_req = 1'b0;
    halt_req = 1'b0;
    fails = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_start;
    t_keys;
    t_period;
    t_modes;
    tally_and_finish;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    tally_and_finish;
  end
endmodule
